/* src/adcsel_pkg.sv */
// Register map, field layout and reset values of the converter input selection block
package adcsel_pkg;

    // Sizes
    localparam int AN_COUNT = 13;
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;
    localparam int REG_W    = 16;
    localparam int SEL_W    = 5;
    localparam int IDX_W    = 4;
    localparam int STRB_W   = 4;

    // Byte offsets of the registers
    localparam logic [11:0] OFS_CHSEL  = 12'h000;
    localparam logic [11:0] OFS_SCAN   = 12'h004;
    localparam logic [11:0] OFS_PMODE  = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00c;

    // Channel select field positions
    localparam int CHSEL_POS_A_LSB = 0;
    localparam int CHSEL_NEG_A_BIT = 7;
    localparam int CHSEL_POS_B_LSB = 8;
    localparam int CHSEL_NEG_B_BIT = 15;

    // Implemented bits; all others ignore writes and read zero
    localparam logic [15:0] CHSEL_IMPL_MASK = 16'h9f9f;
    localparam logic [15:0] MASK13_IMPL     = 16'h1fff;

    // Reset values
    localparam logic [15:0] RST_CHSEL = 16'h0000;
    localparam logic [12:0] RST_MASK  = 13'h0000;

    // Positive select codes
    localparam logic [4:0] POS_CODE_MAX = 5'h0c;
    localparam logic [4:0] RSV_CODE_LO  = 5'h06;
    localparam logic [4:0] RSV_CODE_HI  = 5'h08;

    // Status register field positions
    localparam int STAT_PD_BIT      = 0;
    localparam int STAT_VALID_A_BIT = 1;
    localparam int STAT_VALID_B_BIT = 2;
    localparam int STAT_DIG_LSB     = 16;

endpackage

/* src/adcsel_pin_cfg.sv */
// Per-pin digital or analog mode decode for the shared analog pins
`timescale 1ns/1ps
module adcsel_pin_cfg #(
    parameter logic [12:0] AN_PRESENT = 13'h1fff
) (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire logic [adcsel_pkg::AN_COUNT-1:0]   pin_mode_bits,
    input  wire logic                              converter_power_down,
    output logic      [adcsel_pkg::AN_COUNT-1:0]   pin_digital,
    output logic      [adcsel_pkg::AN_COUNT-1:0]   digital_read_en,
    output logic      [adcsel_pkg::AN_COUNT-1:0]   mux_to_ground
);
    import adcsel_pkg::*;

    typedef struct packed {
        logic [AN_COUNT-1:0] dig;
        logic [AN_COUNT-1:0] rd_en;
        logic [AN_COUNT-1:0] gnd;
    } adcsel_pin_state_type;

    adcsel_pin_state_type s_r;
    adcsel_pin_state_type s_nxt;
    logic [AN_COUNT-1:0]  dig_w;
    logic [AN_COUNT-1:0]  gnd_w;

    // Decode of each pin
    for (genvar i = 0; i < AN_COUNT; i++) begin : g_pin
        if (AN_PRESENT[i]) begin : g_present
            // Powered-down converter forces digital mode
            assign dig_w[i] = converter_power_down | pin_mode_bits[i];
            // Ground the mux only while the converter runs and the pin is digital
            assign gnd_w[i] = ~converter_power_down & pin_mode_bits[i];
        end else begin : g_absent
            // No pin behind this bit: it steers nothing
            assign dig_w[i] = 1'b0;
            assign gnd_w[i] = 1'b0;
        end
    end

    // Next state
    always_comb begin
        s_nxt       = s_r;
        s_nxt.dig   = dig_w;
        s_nxt.rd_en = dig_w;
        s_nxt.gnd   = gnd_w;
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pin_digital     = s_r.dig;
    assign digital_read_en = s_r.rd_en;
    assign mux_to_ground   = s_r.gnd;

endmodule

/* src/adcsel_scan_pick.sv */
// Scan step lookup: include flag and negative reference substitution
`timescale 1ns/1ps
module adcsel_scan_pick #(
    parameter logic [12:0] AN_PRESENT = 13'h1fff
) (
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    input  wire logic [adcsel_pkg::AN_COUNT-1:0] scan_include_bits,
    input  wire logic [adcsel_pkg::IDX_W-1:0]    scan_index,
    output logic                                 scan_include,
    output logic                                 scan_use_neg_ref
);
    import adcsel_pkg::*;

    typedef struct packed {
        logic incl;
        logic neg_ref;
    } adcsel_scan_state_type;

    adcsel_scan_state_type s_r;
    adcsel_scan_state_type s_nxt;

    // Look up the step; absent inputs sample the negative reference
    always_comb begin
        s_nxt         = s_r;
        s_nxt.incl    = 1'b0;
        s_nxt.neg_ref = 1'b0;
        if (32'(scan_index) < AN_COUNT) begin
            s_nxt.incl    = scan_include_bits[scan_index];
            s_nxt.neg_ref = scan_include_bits[scan_index]
                          & ~AN_PRESENT[scan_index];
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign scan_include     = s_r.incl;
    assign scan_use_neg_ref = s_r.neg_ref;

endmodule

/* src/adcsel_top.sv */
// Converter input selection registers with APB access and input routing outputs
`timescale 1ns/1ps
module adcsel_top #(
    parameter logic [12:0] AN_PRESENT = 13'h1fff,
    parameter bit          SMALL_PKG  = 1'b0
) (
    input  wire logic                              CORE_CLK,
    input  wire logic                              NRST,
    input  wire logic                              PSEL,
    input  wire logic                              PENABLE,
    input  wire logic                              PWRITE,
    input  wire logic [adcsel_pkg::ADDR_W-1:0]     PADDR,
    input  wire logic [adcsel_pkg::DATA_W-1:0]     PWDATA,
    input  wire logic [adcsel_pkg::STRB_W-1:0]     PSTRB,
    output logic      [adcsel_pkg::DATA_W-1:0]     PRDATA,
    output logic                                   PREADY,
    output logic                                   PSLVERR,
    input  wire logic                              CONVERTER_POWER_DOWN,
    input  wire logic                              SAMPLE_SLOT_B,
    input  wire logic [adcsel_pkg::IDX_W-1:0]      SCAN_INDEX,
    output logic      [adcsel_pkg::SEL_W-1:0]      CH0_POS_SEL,
    output logic                                   CH0_POS_VALID,
    output logic                                   CH0_NEG_IS_AN1,
    output logic                                   SCAN_INCLUDE,
    output logic                                   SCAN_USE_NEG_REF,
    output logic      [adcsel_pkg::AN_COUNT-1:0]   PIN_DIGITAL,
    output logic      [adcsel_pkg::AN_COUNT-1:0]   DIGITAL_READ_EN,
    output logic      [adcsel_pkg::AN_COUNT-1:0]   MUX_TO_GROUND
);
    import adcsel_pkg::*;

    // Elaboration checks
    if (SMALL_PKG && (AN_PRESENT[8:6] != 3'b000)) begin : g_chk_pkg
        $error("Small package cannot provide analog inputs 6 to 8");
    end
    if (AN_PRESENT == 13'h0000) begin : g_chk_present
        $error("At least one analog input must be present");
    end
    // Each mask register keeps one bit per input in 16 bits
    if (AN_COUNT > REG_W) begin : g_chk_width
        $error("Analog input count exceeds the register width");
    end
    // The pin copy in the status word must fit the data bus
    if (STAT_DIG_LSB + AN_COUNT > DATA_W) begin : g_chk_status
        $error("Status pin field does not fit the data bus");
    end
    // Valid flags must sit below the pin copy
    if ((STAT_VALID_A_BIT >= STAT_DIG_LSB) || (STAT_VALID_B_BIT >= STAT_DIG_LSB)) begin : g_chk_flags
        $error("Status flags overlap the pin field");
    end
    // The highest select code must name the last analog input
    if (int'(POS_CODE_MAX) != AN_COUNT - 1) begin : g_chk_code
        $error("Select code range does not match the input count");
    end
    // The scan index must be able to name every input
    if ((1 << IDX_W) < AN_COUNT) begin : g_chk_index
        $error("Scan index too narrow for the input count");
    end
    // Reserved codes must lie inside the usable code range
    if ((RSV_CODE_LO > RSV_CODE_HI) || (RSV_CODE_HI > POS_CODE_MAX)) begin : g_chk_rsv
        $error("Reserved code range lies outside the select codes");
    end
    // Two byte lanes carry each 16-bit register
    if ((STRB_W * 8 != DATA_W) || (REG_W != 16)) begin : g_chk_lanes
        $error("Byte lane layout does not match the register width");
    end
    // Every input keeps a writable mask bit
    if (MASK13_IMPL != 16'((1 << AN_COUNT) - 1)) begin : g_chk_mask
        $error("Implemented mask bits do not cover every input");
    end
    // Registers must come out of reset cleared
    if ((RST_CHSEL != 16'h0000) || (RST_MASK != 13'h0000)) begin : g_chk_rst
        $error("Register reset values must be zero");
    end
    // Select fields and negative bits must not overlap
    if ((CHSEL_POS_A_LSB + SEL_W > CHSEL_NEG_A_BIT) ||
        (CHSEL_POS_B_LSB + SEL_W > CHSEL_NEG_B_BIT)) begin : g_chk_fields
        $error("Channel select fields overlap");
    end
    // Registers sit on aligned words of the bus
    if ((OFS_CHSEL[1:0] | OFS_SCAN[1:0] | OFS_PMODE[1:0] | OFS_STATUS[1:0])
        != 2'b00) begin : g_chk_align
        $error("Register offsets must be word aligned");
    end
    // Offsets are decoded on the full 12-bit address
    if (ADDR_W != 12) begin : g_chk_addr
        $error("Address width must be 12 bits");
    end

    typedef struct packed {
        logic [REG_W-1:0]    chsel;
        logic [AN_COUNT-1:0] scan;
        logic [AN_COUNT-1:0] pmode;
        logic [DATA_W-1:0]   prdata;
        logic                pready;
        logic                pslverr;
        logic [SEL_W-1:0]    pos_sel;
        logic                pos_valid;
        logic                neg_an1;
    } adcsel_top_state_type;

    // Registered state and its next value
    adcsel_top_state_type s_r;
    adcsel_top_state_type s_nxt;

    // Registered results of the pin decode and the scan lookup
    logic [AN_COUNT-1:0] pin_dig_w;
    logic [AN_COUNT-1:0] rd_en_w;
    logic [AN_COUNT-1:0] gnd_w;
    logic                incl_w;
    logic                neg_ref_w;

    // A positive code is usable when in range and not reserved for the package
    function automatic logic pos_code_ok(input logic [SEL_W-1:0] code);
        logic ok;
        ok = (code <= POS_CODE_MAX);
        if (SMALL_PKG && (code >= RSV_CODE_LO) && (code <= RSV_CODE_HI)) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    // Merge byte lanes 0 and 1 of a write into a 16-bit register
    function automatic logic [REG_W-1:0] lane_merge(input logic [REG_W-1:0] old_v,
                                                    input logic [DATA_W-1:0] wdata,
                                                    input logic [STRB_W-1:0] strb);
        logic [REG_W-1:0] v;
        v = old_v;
        if (strb[0]) begin
            v[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            v[15:8] = wdata[15:8];
        end
        return v;
    endfunction

    // Register read value by address
    function automatic logic [DATA_W-1:0] read_mux(input adcsel_top_state_type st,
                                                   input logic [ADDR_W-1:0] addr,
                                                   input logic [AN_COUNT-1:0] dig);
        logic [DATA_W-1:0] d;
        d = '0;
        case (addr)
            OFS_CHSEL: begin
                d[REG_W-1:0] = st.chsel & CHSEL_IMPL_MASK;
            end
            OFS_SCAN: begin
                d[AN_COUNT-1:0] = st.scan;
            end
            OFS_PMODE: begin
                d[AN_COUNT-1:0] = st.pmode;
            end
            OFS_STATUS: begin
                d[STAT_PD_BIT]      = CONVERTER_POWER_DOWN;
                d[STAT_VALID_A_BIT] = pos_code_ok(st.chsel[CHSEL_POS_A_LSB +: SEL_W]);
                d[STAT_VALID_B_BIT] = pos_code_ok(st.chsel[CHSEL_POS_B_LSB +: SEL_W]);
                d[STAT_DIG_LSB +: AN_COUNT] = dig;
            end
            default: begin
                d = '0;
            end
        endcase
        return d;
    endfunction

    // Address decode of the mapped registers
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
        logic h;
        case (addr)
            OFS_CHSEL, OFS_SCAN, OFS_PMODE, OFS_STATUS: begin
                h = 1'b1;
            end
            default: begin
                h = 1'b0;
            end
        endcase
        return h;
    endfunction

    // Bus slave, register writes and slot routing
    always_comb begin
        logic             setup;
        logic             access;
        logic [SEL_W-1:0] code;
        logic [REG_W-1:0] wv;
        // Phase of the transfer; the access completes while ready stands
        setup  = PSEL & ~PENABLE;
        access = PSEL & PENABLE & s_r.pready;
        code   = '0;
        wv     = '0;

        // Ready and error stand for one cycle, then drop
        s_nxt  = s_r;
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;

        // Setup cycle: prepare answer for the access phase
        if (setup) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = ~addr_hit(PADDR);
            s_nxt.prdata  = PWRITE ? '0 : read_mux(s_r, PADDR, pin_dig_w);
        end else if (access) begin
            s_nxt.prdata = '0;
        end

        // Access phase: writes take effect at its completing edge
        if (access && PWRITE && !s_r.pslverr) begin
            case (PADDR)
                OFS_CHSEL: begin
                    s_nxt.chsel = lane_merge(s_r.chsel, PWDATA, PSTRB) & CHSEL_IMPL_MASK;
                end
                OFS_SCAN: begin
                    wv = lane_merge({3'b000, s_r.scan}, PWDATA, PSTRB);
                    s_nxt.scan = wv[AN_COUNT-1:0];
                end
                OFS_PMODE: begin
                    wv = lane_merge({3'b000, s_r.pmode}, PWDATA, PSTRB);
                    s_nxt.pmode = wv[AN_COUNT-1:0];
                end
                default: begin
                    s_nxt.chsel = s_r.chsel;
                end
            endcase
        end

        // Route the channel 0 inputs of the active sample slot
        if (SAMPLE_SLOT_B) begin
            code          = s_r.chsel[CHSEL_POS_B_LSB +: SEL_W];
            s_nxt.neg_an1 = s_r.chsel[CHSEL_NEG_B_BIT];
        end else begin
            code          = s_r.chsel[CHSEL_POS_A_LSB +: SEL_W];
            s_nxt.neg_an1 = s_r.chsel[CHSEL_NEG_A_BIT];
        end
        // Code is passed on as stored; only the valid flag marks reserved codes
        s_nxt.pos_sel   = code;
        s_nxt.pos_valid = pos_code_ok(code);
    end

    // State register
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            // Clear all, then load each register's reset value
            s_r           <= '0;
            s_r.chsel     <= RST_CHSEL;
            s_r.scan      <= RST_MASK;
            s_r.pmode     <= RST_MASK;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Pin mode decode
    adcsel_pin_cfg #(
        .AN_PRESENT (AN_PRESENT)
    ) u_pin_cfg (
        .clk                  (CORE_CLK),
        .rst_n                (NRST),
        .pin_mode_bits        (s_r.pmode),
        .converter_power_down (CONVERTER_POWER_DOWN),
        .pin_digital          (pin_dig_w),
        .digital_read_en      (rd_en_w),
        .mux_to_ground        (gnd_w)
    );

    // Scan step lookup
    adcsel_scan_pick #(
        .AN_PRESENT (AN_PRESENT)
    ) u_scan_pick (
        .clk               (CORE_CLK),
        .rst_n             (NRST),
        .scan_include_bits (s_r.scan),
        .scan_index        (SCAN_INDEX),
        .scan_include      (incl_w),
        .scan_use_neg_ref  (neg_ref_w)
    );

    // Outputs, all from flip-flops
    assign PRDATA           = s_r.prdata;
    assign PREADY           = s_r.pready;
    assign PSLVERR          = s_r.pslverr;
    assign CH0_POS_SEL      = s_r.pos_sel;
    assign CH0_POS_VALID    = s_r.pos_valid;
    assign CH0_NEG_IS_AN1   = s_r.neg_an1;
    assign SCAN_INCLUDE     = incl_w;
    assign SCAN_USE_NEG_REF = neg_ref_w;
    assign PIN_DIGITAL      = pin_dig_w;
    assign DIGITAL_READ_EN  = rd_en_w;
    assign MUX_TO_GROUND    = gnd_w;

endmodule

/* verif/adcsel_chk.sv */
// Assertion checker for the converter input selection block
`timescale 1ns/1ps
module adcsel_chk #(
    parameter logic [12:0] AN_PRESENT = 13'h1fff,
    parameter bit          SMALL_PKG  = 1'b0
) (
    input wire logic                            CORE_CLK,
    input wire logic                            NRST,
    input wire logic                            PSEL,
    input wire logic                            PENABLE,
    input wire logic                            PWRITE,
    input wire logic [adcsel_pkg::ADDR_W-1:0]   PADDR,
    input wire logic [adcsel_pkg::DATA_W-1:0]   PRDATA,
    input wire logic                            PREADY,
    input wire logic                            PSLVERR,
    input wire logic                            CONVERTER_POWER_DOWN,
    input wire logic [adcsel_pkg::IDX_W-1:0]    SCAN_INDEX,
    input wire logic [adcsel_pkg::SEL_W-1:0]    CH0_POS_SEL,
    input wire logic                            CH0_POS_VALID,
    input wire logic                            SCAN_INCLUDE,
    input wire logic                            SCAN_USE_NEG_REF,
    input wire logic [adcsel_pkg::AN_COUNT-1:0] PIN_DIGITAL,
    input wire logic [adcsel_pkg::AN_COUNT-1:0] DIGITAL_READ_EN,
    input wire logic [adcsel_pkg::AN_COUNT-1:0] MUX_TO_GROUND
);
    import adcsel_pkg::*;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    // Bus steps: setup cycle, completing access, single-cycle answer
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_access;
        PSEL && PENABLE && PREADY;
    endsequence
    sequence s_answer;
        PREADY ##1 !PREADY;
    endsequence
    property p_ready_pulse;
        s_setup |=> s_answer;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("Ready not a single pulse");
    property p_unmapped;
        s_access ##0 (PADDR > OFS_STATUS || PADDR[1:0] != 2'b00) |-> PSLVERR && PRDATA == 0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped access not refused");
    property p_unimpl;
        s_access ##0 (!PWRITE && (PADDR == OFS_SCAN || PADDR == OFS_PMODE)) |-> PRDATA[31:13] == 0;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("Upper mask bits read non-zero");
    property p_pos_valid;
        $past(NRST, 2) |-> CH0_POS_VALID == (CH0_POS_SEL <= POS_CODE_MAX &&
            !(SMALL_PKG && CH0_POS_SEL >= RSV_CODE_LO && CH0_POS_SEL <= RSV_CODE_HI));
    endproperty
    a_pos_valid: assert property (p_pos_valid) else $error("Select code validity wrong");
    property p_read_en;
        DIGITAL_READ_EN == PIN_DIGITAL && (MUX_TO_GROUND & ~PIN_DIGITAL) == 0;
    endproperty
    a_read_en: assert property (p_read_en) else $error("Read path or ground mismatch");
    property p_absent;
        ((PIN_DIGITAL | MUX_TO_GROUND) & ~AN_PRESENT) == 0;
    endproperty
    a_absent: assert property (p_absent) else $error("Absent pin affected");
    property p_power_down;
        $past(NRST) && $past(CONVERTER_POWER_DOWN) |-> PIN_DIGITAL == AN_PRESENT && MUX_TO_GROUND == 0;
    endproperty
    a_power_down: assert property (p_power_down) else $error("Power-down not all digital");
    property p_scan_pick;
        $past(NRST, 2) && $past(SCAN_INDEX) <= 12 |->
            SCAN_USE_NEG_REF == (SCAN_INCLUDE && !AN_PRESENT[$past(SCAN_INDEX)]);
    endproperty
    a_scan_pick: assert property (p_scan_pick) else $error("Negative reference pick wrong");
    property p_scan_range;
        $past(SCAN_INDEX) > 12 |-> !SCAN_INCLUDE && !SCAN_USE_NEG_REF;
    endproperty
    a_scan_range: assert property (p_scan_range) else $error("Scan index above 12 included");
endmodule

bind adcsel_top adcsel_chk #(.AN_PRESENT(AN_PRESENT), .SMALL_PKG(SMALL_PKG)) u_chk (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CONVERTER_POWER_DOWN(CONVERTER_POWER_DOWN), .SCAN_INDEX(SCAN_INDEX),
    .CH0_POS_SEL(CH0_POS_SEL), .CH0_POS_VALID(CH0_POS_VALID), .SCAN_INCLUDE(SCAN_INCLUDE),
    .SCAN_USE_NEG_REF(SCAN_USE_NEG_REF), .PIN_DIGITAL(PIN_DIGITAL),
    .DIGITAL_READ_EN(DIGITAL_READ_EN), .MUX_TO_GROUND(MUX_TO_GROUND));

/* verif/adc_input_select_config_bench.sv */
// Self-checking bench for the converter input selection block
`timescale 1ns/1ps
module adc_input_select_config_bench;
    import adcsel_pkg::*;
    localparam logic [12:0] PRESENT = 13'h1e3f; // Inputs 6 to 8 absent
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, pd, slot_b;
    logic        pos_valid, neg_an1, scan_inc, scan_neg, err, exp_v;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  idx;
    logic [4:0]  pos_sel;
    logic [12:0] pin_dig, rd_en, gnd;
    logic [15:0] scan_m = 16'h10a5;
    logic [15:0] pres16 = {3'b111, PRESENT};
    logic [11:0] ofs[3] = '{OFS_CHSEL, OFS_SCAN, OFS_PMODE};
    logic [15:0] impl[3] = '{CHSEL_IMPL_MASK, MASK13_IMPL, MASK13_IMPL};
    int          n_errors = 0;
    int          total_checks = 0;

    adcsel_top #(.AN_PRESENT(PRESENT), .SMALL_PKG(1'b1)) dut (
        .CORE_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CONVERTER_POWER_DOWN(pd), .SAMPLE_SLOT_B(slot_b),
        .SCAN_INDEX(idx), .CH0_POS_SEL(pos_sel), .CH0_POS_VALID(pos_valid),
        .CH0_NEG_IS_AN1(neg_an1), .SCAN_INCLUDE(scan_inc), .SCAN_USE_NEG_REF(scan_neg),
        .PIN_DIGITAL(pin_dig), .DIGITAL_READ_EN(rd_en), .MUX_TO_GROUND(gnd));

    // Compare one result and count it
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus transfer, held until ready is seen at an edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) check("ready", 32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Let the registered outputs follow a change
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic final_report;
        $display("Errors %0d of %0d checks", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cut a hang short far beyond the expected few hundred cycles
    initial begin
        #200000;
        n_errors++;
        final_report;
    end

    // Reset, then registers, pins, scan and select scenarios
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pd = 1'b0;
        slot_b = 1'b0;
        idx = 4'h0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        settle;
        check("pins after reset", 32'h0, 32'(pin_dig));
        foreach (ofs[i]) begin
            xfer(1'b0, ofs[i], 32'h0);
            check("reset value", 32'h0, rd);
            xfer(1'b1, ofs[i], 32'hffffffff);
            xfer(1'b0, ofs[i], 32'h0);
            check("readback", {16'h0, impl[i]}, rd);
            xfer(1'b1, ofs[i], 32'h0);
        end
        xfer(1'b0, 12'h010, 32'h0);
        check("unmapped error", 32'h1, 32'(err));
        check("unmapped data", 32'h0, rd);
        xfer(1'b1, OFS_PMODE, 32'h000001c5);
        settle;
        check("digital", 32'(13'h01c5 & PRESENT), 32'(pin_dig));
        check("read enable", 32'(13'h01c5 & PRESENT), 32'(rd_en));
        check("ground", 32'(13'h01c5 & PRESENT), 32'(gnd));
        @(posedge clk);
        pd <= 1'b1;
        settle;
        check("digital off", 32'(PRESENT), 32'(pin_dig));
        check("ground off", 32'h0, 32'(gnd));
        xfer(1'b0, OFS_STATUS, 32'h0);
        check("status", {3'b000, PRESENT, 13'h0000, 3'b111}, rd);
        @(posedge clk);
        pd <= 1'b0;
        xfer(1'b1, OFS_PMODE, 32'h0);
        settle;
        check("analog", 32'h0, 32'(pin_dig | rd_en | gnd));
        xfer(1'b1, OFS_SCAN, 32'(scan_m));
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            idx <= 4'(i);
            settle;
            check("include", 32'(scan_m[i]), 32'(scan_inc));
            check("neg ref", 32'(scan_m[i] && !pres16[i]), 32'(scan_neg));
        end
        for (int c = 0; c < 32; c++) begin
            xfer(1'b1, OFS_CHSEL, {19'h0, 5'(c), 3'b100, 5'(c)});
            settle;
            exp_v = c <= 12 && !(c >= 6 && c <= 8);
            check("pos select", 32'(c), 32'(pos_sel));
            check("pos valid", 32'(exp_v), 32'(pos_valid));
            check("neg select a", 32'h1, 32'(neg_an1));
            @(posedge clk);
            slot_b <= 1'b1;
            settle;
            check("pos select b", 32'(c), 32'(pos_sel));
            check("neg select b", 32'h0, 32'(neg_an1));
            @(posedge clk);
            slot_b <= 1'b0;
        end
        // Reset again in mid-run with registers loaded
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        settle;
        check("pos select reset", 32'h0, 32'(pos_sel));
        check("neg select reset", 32'h0, 32'(neg_an1));
        foreach (ofs[i]) begin
            xfer(1'b0, ofs[i], 32'h0);
            check("reset again", 32'h0, rd);
        end
        final_report;
    end
endmodule
